// file: design/cpu_control_regs_paging.sv
// core register set with paging, interrupt acceptance and ahb-lite access
//
// Behaviour
// RULE_01 - trace flag set raises trace after instructions
// RULE_02 - reset clears trace flag
// RULE_03 - status bits 14-11, 7-4 read zero
// RULE_04 - maskable accepted only above mask level
// RULE_05 - nonmaskable level 8 always accepted
// RULE_06 - acceptance loads mask with level, nmi seven
// RULE_07 - reset sets all mask bits
// RULE_08 - negative flag copies result msb
// RULE_09 - zero flag marks zero result
// RULE_10 - overflow flag marks arithmetic overflow
// RULE_11 - carry set on carry, else clear/keep
// RULE_12 - condition byte accessible on its own
// RULE_13 - page registers used only in larger mode
// RULE_14 - fetch address is code page plus pc
// RULE_15 - code page from vector, saved with pc (reset loads cp with 8'h00, no vector is read)
// RULE_16 - data page for r0-r3 and abs16
// RULE_17 - extended page for r4 and r5
// RULE_18 - stack page for r6, r7, stack
// RULE_19 - short absolute uses base, page zero
// RULE_20 - r7 stack pointer, predec store, postinc load
// RULE_21 - r6 frame pointer for frame instructions
// RULE_22 - eight interchangeable registers, byte or word
// RULE_23 - byte operations keep upper byte
// RULE_24 - modes 3 and 4 larger, else smaller
// RULE_25 - sp, base and pages not reset (the code page resets to 8'h00)
// RULE_26 - smaller mode addresses in page zero
module cpu_control_regs_paging
	import cpu_regs_pkg::*;
#(
	parameter int NUM_GEN = 8
) (
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic             trace_exc_out,
	output logic      [23:0] fetch_addr_out,
	output logic      [23:0] ea_addr_out
);
	initial begin
		if (NUM_GEN != 8)
			$error("register set needs exactly eight general registers");
	end

	typedef struct packed {
		logic [NUM_GEN-1:0][15:0] gen;
		logic [15:0] pc;
		logic [15:0] status;
		logic [7:0]  cp;
		logic [7:0]  dp;
		logic [7:0]  ep;
		logic [7:0]  tp;
		logic [7:0]  br;
		logic [2:0]  mode;
		logic [3:0]  irq_level;
		logic        irq_taken;
		logic [3:0]  taken_level;
		logic        exc_saved;
		logic [15:0] saved_pc;
		logic [7:0]  saved_cp;
		logic [15:0] ea_req;
		bus_phase_t  phase;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] rdata;
		logic        trace_exc;
		logic [23:0] fetch;
		logic [23:0] ea;
	} state_t;

	state_t s_reg;
	state_t s_next;

	function automatic logic larger_mode(input logic [2:0] m);
		larger_mode = (m == 3'h3) || (m == 3'h4); // RULE_24
	endfunction

	function automatic logic [23:0] page_addr(input logic [2:0] m,
			input logic [7:0] page, input logic [15:0] low);
		if (larger_mode(m))
			page_addr = {page, low}; // RULE_13
		else
			page_addr = {8'h00, low}; // RULE_26
	endfunction

	function automatic logic gen_hit(input logic [7:0] a);
		gen_hit = (a >= OFF_GEN_BASE) && (a < OFF_GEN_BASE + 8'h20);
	endfunction

	// decode assumes aligned words and no overlap with the general window
	initial begin
		if (OFF_PROGRAM_COUNTER[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_STATUS_WORD[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_COND_CODE_BYTE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_CODE_PAGE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_DATA_PAGE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_EXTENDED_PAGE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_STACK_PAGE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_SHORT_ADDR_BASE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_MODE_CTRL[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_IRQ_REQ[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_IRQ_STAT[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_ALU_RESULT[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_EXC_CTRL[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_EA_REQ[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_EA_RESULT[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (OFF_GEN_BASE[1:0] != 2'b00)
			$error("register offset not word aligned");
		if (gen_hit(OFF_PROGRAM_COUNTER))
			$error("register offset inside general window");
		if (gen_hit(OFF_STATUS_WORD))
			$error("register offset inside general window");
		if (gen_hit(OFF_COND_CODE_BYTE))
			$error("register offset inside general window");
		if (gen_hit(OFF_CODE_PAGE))
			$error("register offset inside general window");
		if (gen_hit(OFF_DATA_PAGE))
			$error("register offset inside general window");
		if (gen_hit(OFF_EXTENDED_PAGE))
			$error("register offset inside general window");
		if (gen_hit(OFF_STACK_PAGE))
			$error("register offset inside general window");
		if (gen_hit(OFF_SHORT_ADDR_BASE))
			$error("register offset inside general window");
		if (gen_hit(OFF_MODE_CTRL))
			$error("register offset inside general window");
		if (gen_hit(OFF_IRQ_REQ))
			$error("register offset inside general window");
		if (gen_hit(OFF_IRQ_STAT))
			$error("register offset inside general window");
		if (gen_hit(OFF_ALU_RESULT))
			$error("register offset inside general window");
		if (gen_hit(OFF_EXC_CTRL))
			$error("register offset inside general window");
		if (gen_hit(OFF_EA_REQ))
			$error("register offset inside general window");
		if (gen_hit(OFF_EA_RESULT))
			$error("register offset inside general window");
		if ((STATUS_WRITE_MASK & 16'h78F0) != 16'h0000)
			$error("status write mask opens reserved bits");
		if (STATUS_RESET[TRACE_BIT] != 1'b0)
			$error("status reset value must clear trace");
		if (STATUS_RESET[10:8] != MASK_ALL)
			$error("status reset value must set whole mask");
		if (NMI_LEVEL != 4'h8)
			$error("nonmaskable level must be eight");
		if (FLAG_N_BIT > 3)
			$error("flag position outside condition nibble");
		if (FLAG_Z_BIT > 3)
			$error("flag position outside condition nibble");
		if (FLAG_V_BIT > 3)
			$error("flag position outside condition nibble");
		if (FLAG_C_BIT > 3)
			$error("flag position outside condition nibble");
	end

	logic        ahb_take;
	logic [2:0]  gidx;
	logic [2:0]  ea_reg_sel;
	logic [7:0]  ea_low8;
	ea_kind_t    ea_kind;
	logic [7:0]  ea_page;
	logic [15:0] alu_res;
	logic        byte_op;

	always_comb begin
		s_next = s_reg;
		s_next.trace_exc = 1'b0;
		ahb_take = hsel_in && hready_in && htrans_in[1];
		gidx = s_reg.addr[4:2];
		ea_kind = ea_kind_t'(s_reg.ea_req[12:11]);
		ea_reg_sel = s_reg.ea_req[10:8];
		ea_low8 = s_reg.ea_req[7:0];
		alu_res = hwdata_in[15:0];
		byte_op = hwdata_in[20];
		ea_page = s_reg.dp;
		// irq acceptance against the current mask
		if (s_reg.irq_level == NMI_LEVEL) begin
			s_next.irq_taken = 1'b1; // RULE_05
			s_next.taken_level = NMI_LEVEL;
			s_next.status[10:8] = MASK_ALL; // RULE_06
			s_next.irq_level = 4'h0;
		end else if (s_reg.irq_level != 4'h0 &&
				s_reg.irq_level[2:0] > s_reg.status[10:8]) begin
			s_next.irq_taken = 1'b1; // RULE_04
			s_next.taken_level = s_reg.irq_level;
			s_next.status[10:8] = s_reg.irq_level[2:0]; // RULE_06
			s_next.irq_level = 4'h0;
		end
		// address formation, one cycle behind the request
		s_next.fetch = page_addr(s_reg.mode, s_reg.cp, s_reg.pc); // RULE_14
		case (ea_kind)
			EA_CODE:
				s_next.ea = page_addr(s_reg.mode, s_reg.cp, s_reg.pc);
			EA_INDIRECT: begin
				if (ea_reg_sel < 3'h4)
					ea_page = s_reg.dp; // RULE_16
				else if (ea_reg_sel < 3'h6)
					ea_page = s_reg.ep; // RULE_17
				else
					ea_page = s_reg.tp; // RULE_18
				s_next.ea = page_addr(s_reg.mode, ea_page,
					s_reg.gen[ea_reg_sel]); // RULE_22
			end
			EA_ABS16:
				s_next.ea = page_addr(s_reg.mode, s_reg.dp,
					s_reg.ea_req); // RULE_16
			EA_SHORT:
				s_next.ea = {8'h00, s_reg.br, ea_low8}; // RULE_19
			default:
				s_next.ea = 24'h000000;
		endcase
		// data phase of the previous address phase
		if (s_reg.phase == BUS_DATA && s_reg.wr) begin
			if (gen_hit(s_reg.addr)) begin
				if (hwdata_in[16])
					s_next.gen[gidx][7:0] = hwdata_in[7:0]; // RULE_23
				else
					s_next.gen[gidx] = hwdata_in[15:0]; // RULE_22
			end else if (s_reg.addr == OFF_PROGRAM_COUNTER) begin
				s_next.pc = hwdata_in[15:0];
				s_next.trace_exc = s_reg.status[TRACE_BIT]; // RULE_01
			end else if (s_reg.addr == OFF_STATUS_WORD)
				s_next.status = hwdata_in[15:0] & STATUS_WRITE_MASK; // RULE_03
			else if (s_reg.addr == OFF_COND_CODE_BYTE)
				s_next.status[7:0] = hwdata_in[7:0] & 8'h0F; // RULE_12
			else if (s_reg.addr == OFF_CODE_PAGE)
				s_next.cp = hwdata_in[7:0]; // RULE_15
			else if (s_reg.addr == OFF_DATA_PAGE)
				s_next.dp = hwdata_in[7:0]; // RULE_16
			else if (s_reg.addr == OFF_EXTENDED_PAGE)
				s_next.ep = hwdata_in[7:0];
			else if (s_reg.addr == OFF_STACK_PAGE)
				s_next.tp = hwdata_in[7:0];
			else if (s_reg.addr == OFF_SHORT_ADDR_BASE)
				s_next.br = hwdata_in[7:0];
			else if (s_reg.addr == OFF_MODE_CTRL)
				s_next.mode = hwdata_in[2:0];
			else if (s_reg.addr == OFF_IRQ_REQ)
				s_next.irq_level = hwdata_in[3:0];
			else if (s_reg.addr == OFF_IRQ_STAT) begin
				// a new acceptance in this cycle outranks the clear only when irq_taken was low
				if (!(s_next.irq_taken && !s_reg.irq_taken))
					s_next.irq_taken = 1'b0;
			end else if (s_reg.addr == OFF_ALU_RESULT) begin
				// flag update from a result: bit 17 v, bit 18 c, 19 keep c
				if (byte_op) begin
					s_next.status[FLAG_N_BIT] = alu_res[7]; // RULE_08
					s_next.status[FLAG_Z_BIT] = alu_res[7:0] == 8'h00; // RULE_09
				end else begin
					s_next.status[FLAG_N_BIT] = alu_res[15]; // RULE_08
					s_next.status[FLAG_Z_BIT] = alu_res == 16'h0000; // RULE_09
				end
				s_next.status[FLAG_V_BIT] = hwdata_in[17]; // RULE_10
				if (hwdata_in[18])
					s_next.status[FLAG_C_BIT] = 1'b1; // RULE_11
				else if (!hwdata_in[19])
					s_next.status[FLAG_C_BIT] = 1'b0; // RULE_11
			end else if (s_reg.addr == OFF_EXC_CTRL) begin
				if (hwdata_in[0]) begin
					// save: push through stack pointer, predecrement
					s_next.saved_pc = s_reg.pc;
					s_next.saved_cp = s_reg.cp; // RULE_15
					s_next.exc_saved = 1'b1;
					s_next.gen[7] = s_reg.gen[7] - 16'h0004; // RULE_20
				end else if (hwdata_in[1] && s_reg.exc_saved) begin
					s_next.pc = s_reg.saved_pc;
					s_next.cp = s_reg.saved_cp; // RULE_15
					s_next.exc_saved = 1'b0;
					s_next.gen[7] = s_reg.gen[7] + 16'h0004; // RULE_20
				end else if (hwdata_in[2])
					s_next.gen[6] = s_reg.gen[7]; // RULE_21
				else if (hwdata_in[3])
					s_next.gen[7] = s_reg.gen[6]; // RULE_21
			end else if (s_reg.addr == OFF_EA_REQ)
				s_next.ea_req = hwdata_in[15:0];
		end
		// read answer formed in the address phase
		s_next.phase = BUS_IDLE;
		if (ahb_take) begin
			s_next.phase = BUS_DATA;
			s_next.wr = hwrite_in;
			s_next.addr = haddr_in[7:0];
			s_next.rdata = 32'h00000000;
			if (gen_hit(haddr_in[7:0]))
				s_next.rdata = {16'h0000, s_reg.gen[haddr_in[4:2]]};
			else if (haddr_in[7:0] == OFF_PROGRAM_COUNTER)
				s_next.rdata = {16'h0000, s_reg.pc};
			else if (haddr_in[7:0] == OFF_STATUS_WORD)
				s_next.rdata = {16'h0000, s_reg.status & STATUS_WRITE_MASK}; // RULE_03
			else if (haddr_in[7:0] == OFF_COND_CODE_BYTE)
				s_next.rdata = {24'h000000, s_reg.status[7:0]}; // RULE_12
			else if (haddr_in[7:0] == OFF_CODE_PAGE)
				s_next.rdata = {24'h000000, s_reg.cp};
			else if (haddr_in[7:0] == OFF_DATA_PAGE)
				s_next.rdata = {24'h000000, s_reg.dp};
			else if (haddr_in[7:0] == OFF_EXTENDED_PAGE)
				s_next.rdata = {24'h000000, s_reg.ep};
			else if (haddr_in[7:0] == OFF_STACK_PAGE)
				s_next.rdata = {24'h000000, s_reg.tp};
			else if (haddr_in[7:0] == OFF_SHORT_ADDR_BASE)
				s_next.rdata = {24'h000000, s_reg.br};
			else if (haddr_in[7:0] == OFF_MODE_CTRL)
				s_next.rdata = {29'h00000000, s_reg.mode};
			else if (haddr_in[7:0] == OFF_IRQ_STAT)
				s_next.rdata = {27'h0000000, s_reg.taken_level,
					s_reg.irq_taken};
			else if (haddr_in[7:0] == OFF_EA_RESULT)
				s_next.rdata = {8'h00, s_reg.ea};
		end
	end

	// sp, base, data, extended and stack pages hold whatever they had; only code page and control state reset
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin // RULE_25
			s_reg.pc <= 16'h0000;
			s_reg.status <= STATUS_RESET; // RULE_02 RULE_07
			s_reg.cp <= 8'h00; // RULE_15
			s_reg.mode <= 3'h7;
			s_reg.irq_level <= 4'h0;
			s_reg.irq_taken <= 1'b0;
			s_reg.taken_level <= 4'h0;
			s_reg.exc_saved <= 1'b0;
			s_reg.saved_pc <= 16'h0000;
			s_reg.saved_cp <= 8'h00;
			s_reg.ea_req <= 16'h0000;
			s_reg.phase <= BUS_IDLE;
			s_reg.wr <= 1'b0;
			s_reg.addr <= 8'h00;
			s_reg.rdata <= 32'h00000000;
			s_reg.trace_exc <= 1'b0;
			s_reg.fetch <= 24'h000000;
			s_reg.ea <= 24'h000000;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata_out     = s_reg.rdata;
	assign hreadyout_out  = 1'b1;
	assign hresp_out      = 1'b0;
	assign trace_exc_out  = s_reg.trace_exc;
	assign fetch_addr_out = s_reg.fetch;
	assign ea_addr_out    = s_reg.ea;
endmodule

// file: design/cpu_regs_pkg.sv
// package: register offsets, field positions, reset values and enums
package cpu_regs_pkg;
	localparam logic [7:0] OFF_PROGRAM_COUNTER = 8'h00;
	localparam logic [7:0] OFF_STATUS_WORD     = 8'h04;
	localparam logic [7:0] OFF_COND_CODE_BYTE  = 8'h08;
	localparam logic [7:0] OFF_CODE_PAGE       = 8'h0C;
	localparam logic [7:0] OFF_DATA_PAGE       = 8'h10;
	localparam logic [7:0] OFF_EXTENDED_PAGE   = 8'h14;
	localparam logic [7:0] OFF_STACK_PAGE      = 8'h18;
	localparam logic [7:0] OFF_SHORT_ADDR_BASE = 8'h1C;
	localparam logic [7:0] OFF_MODE_CTRL       = 8'h20;
	localparam logic [7:0] OFF_IRQ_REQ         = 8'h24;
	localparam logic [7:0] OFF_IRQ_STAT        = 8'h28;
	localparam logic [7:0] OFF_ALU_RESULT      = 8'h2C;
	localparam logic [7:0] OFF_EXC_CTRL        = 8'h30;
	localparam logic [7:0] OFF_EA_REQ          = 8'h34;
	localparam logic [7:0] OFF_EA_RESULT       = 8'h38;
	localparam logic [7:0] OFF_GEN_BASE        = 8'h40;
	localparam int TRACE_BIT  = 15;
	localparam int MASK_LSB   = 8;
	localparam int FLAG_N_BIT = 3;
	localparam int FLAG_Z_BIT = 2;
	localparam int FLAG_V_BIT = 1;
	localparam int FLAG_C_BIT = 0;
	localparam logic [15:0] STATUS_WRITE_MASK = 16'h870F;
	localparam logic [15:0] STATUS_RESET      = 16'h0700;
	localparam logic [2:0]  MASK_ALL          = 3'h7;
	localparam logic [3:0]  NMI_LEVEL         = 4'h8;
	typedef enum logic [1:0] {
		EA_CODE     = 2'b00,
		EA_INDIRECT = 2'b01,
		EA_ABS16    = 2'b10,
		EA_SHORT    = 2'b11
	} ea_kind_t;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_DATA = 1'b1
	} bus_phase_t;
endpackage

// file: tb/cpu_regs_monitor.sv
// checker: bus-visible invariants of the core register set
module cpu_regs_monitor
	import cpu_regs_pkg::*;
#(
	parameter int NUM_GEN = 8
) (
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire logic        hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic [2:0]  hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic        hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	input wire logic        trace_exc_out,
	input wire logic [23:0] fetch_addr_out,
	input wire logic [23:0] ea_addr_out
);
	typedef struct packed {
		logic pw, pr, st, sh, sh1, lg, lg1;
		logic [2:0] pc3;
		logic [7:0] pa;
	} mon_t;
	mon_t h;
	logic rs;
	assign rs = h.pr && h.pa == OFF_STATUS_WORD;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			h <= '0;
		end else begin
			h.pw <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
			h.pr <= hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
			h.pa <= haddr_in[7:0];
			h.sh1 <= h.sh;
			h.lg1 <= h.lg;
			h.pc3 <= {h.pc3[1:0], h.pw && h.pa == OFF_PROGRAM_COUNTER};
			// conservative: any write that may move mask or trace
			if (h.pw && h.pa inside {OFF_STATUS_WORD, OFF_IRQ_REQ, OFF_EXC_CTRL})
				h.st <= 1'b1;
			if (h.pw && h.pa == OFF_MODE_CTRL)
				h.lg <= hwdata_in[2:0] inside {3'h3, 3'h4};
			if (h.pw && h.pa == OFF_EA_REQ)
				h.sh <= hwdata_in[12:11] == 2'h3;
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	property p_trace_cause; trace_exc_out |-> h.pc3 != 3'h0; endproperty
	a_trace_cause: assert property (p_trace_cause)
		else $error("trace pulse without pc write");
	property p_trace_rst; !h.st |-> !trace_exc_out; endproperty
	a_trace_rst: assert property (p_trace_rst)
		else $error("trace pulse before trace enabled");
	property p_trace_bit; rs && !h.st |-> !hrdata_out[TRACE_BIT]; endproperty
	a_trace_bit: assert property (p_trace_bit)
		else $error("trace bit set after reset");
	property p_rsvd; rs |-> (hrdata_out & 32'hFFFF_78F0) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved status bits not zero");
	property p_mask_rst; rs && !h.st |-> hrdata_out[10:8] == MASK_ALL; endproperty
	a_mask_rst: assert property (p_mask_rst)
		else $error("mask not all ones after reset");
	property p_ccb;
		h.pr && h.pa == OFF_COND_CODE_BYTE |-> hrdata_out[31:4] == 28'h0;
	endproperty
	a_ccb: assert property (p_ccb)
		else $error("condition byte read has upper bits");
	property p_small; !h.lg && !h.lg1 |-> fetch_addr_out[23:16] == 8'h00;
	endproperty
	a_small: assert property (p_small)
		else $error("page bits used in smaller mode");
	property p_short; h.sh && h.sh1 |-> ea_addr_out[23:16] == 8'h00; endproperty
	a_short: assert property (p_short)
		else $error("short absolute address outside page zero");
endmodule

bind cpu_control_regs_paging cpu_regs_monitor #(.NUM_GEN(NUM_GEN))
	cpu_regs_monitor_inst (.clock_in, .rst_in, .hsel_in, .haddr_in,
	.htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
	.hreadyout_out, .hresp_out, .trace_exc_out, .fetch_addr_out, .ea_addr_out);

// file: tb/cpu_control_regs_paging_bench.sv
// testbench: register access, interrupts, paging and flags over ahb-lite
module cpu_control_regs_paging_bench
	import cpu_regs_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_in, rst_in, hsel, hwrite, hrdy, hresp, trc;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [23:0] fa, ea;
	int          err_total = 0, n_checks = 0, cyc = 0, pulses = 0;
	cpu_control_regs_paging cpu_control_regs_paging_inst (.clock_in,
		.rst_in, .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .trace_exc_out(trc), .fetch_addr_out(fa),
		.ea_addr_out(ea));
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	task report_and_stop;
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cyc++;
		if (trc === 1'b1)
			pulses++;
		// scenarios need well under a thousand cycles
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task xf(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock_in); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_in); while (hrdy !== 1'b1);
		r = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xf(a, 1'b1, d);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		xf(a, 1'b0, 32'h0);
		chk(r, e);
		chk({31'h0, hresp}, 32'h0);
		chk({31'h0, hrdy}, 32'h1);
	endtask
	task t_status;
		rc(OFF_STATUS_WORD, 32'h0700);
		wr(OFF_PROGRAM_COUNTER, 32'h1234);
		repeat (3) @(posedge clock_in);
		chk(32'(pulses), 32'h0);
		wr(OFF_STATUS_WORD, 32'hFFFF_FFFF);
		rc(OFF_STATUS_WORD, 32'h870F);
		wr(OFF_COND_CODE_BYTE, 32'h0000_00F0);
		rc(OFF_COND_CODE_BYTE, 32'h0);
		rc(OFF_STATUS_WORD, 32'h8700);
		pulses = 0;
		wr(OFF_PROGRAM_COUNTER, 32'h2222);
		repeat (3) @(posedge clock_in);
		chk(32'(pulses), 32'h1);
		wr(OFF_STATUS_WORD, 32'h0);
		pulses = 0;
		wr(OFF_PROGRAM_COUNTER, 32'h3333);
		repeat (3) @(posedge clock_in);
		chk(32'(pulses), 32'h0);
		rc(8'hFC, 32'h0);
	endtask
	// mask, level (F: none, earlier one stays pending), taken, new mask
	logic [15:0] it [8] = '{16'h3303, 16'h2F13, 16'h7707, 16'h7817,
		16'h0111, 16'h5616, 16'h6606, 16'h6817};
	task t_irq;
		foreach (it[i]) begin
			wr(OFF_IRQ_STAT, 32'h0);
			wr(OFF_STATUS_WORD, {21'h0, it[i][14:12], 8'h00});
			if (it[i][11:8] != 4'hF)
				wr(OFF_IRQ_REQ, {28'h0, it[i][11:8]});
			repeat (2) @(posedge clock_in);
			xf(OFF_IRQ_STAT, 1'b0, 32'h0);
			chk({31'h0, r[0]}, {31'h0, it[i][4]});
			rc(OFF_STATUS_WORD, {21'h0, it[i][2:0], 8'h00});
		end
	endtask
	logic [7:0] pg [8] = '{8'h21, 8'h21, 8'h21, 8'h21, 8'h43, 8'h43,
		8'h65, 8'h65};
	logic [2:0] md [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
	task t_pages;
		wr(OFF_MODE_CTRL, 32'h4);
		wr(OFF_CODE_PAGE, 32'h12);
		wr(OFF_PROGRAM_COUNTER, 32'h3456);
		wr(OFF_DATA_PAGE, 32'h21);
		wr(OFF_EXTENDED_PAGE, 32'h43);
		wr(OFF_STACK_PAGE, 32'h65);
		wr(OFF_SHORT_ADDR_BASE, 32'h9A);
		for (int i = 0; i < 8; i++)
			wr(OFF_GEN_BASE + 8'(i * 4), 32'h1000 + 32'(i));
		repeat (2) @(posedge clock_in);
		chk({8'h0, fa}, 32'h123456);
		for (int i = 0; i < 8; i++) begin
			wr(OFF_EA_REQ, 32'h0800 + 32'(i * 256));
			repeat (2) @(posedge clock_in);
			chk({8'h0, ea}, {8'h0, pg[i], 16'h1000 + 16'(i)});
		end
		wr(OFF_EA_REQ, 32'h187C);
		repeat (2) @(posedge clock_in);
		chk({8'h0, ea}, 32'h9A7C);
		foreach (md[i]) begin
			wr(OFF_MODE_CTRL, {29'h0, md[i]});
			repeat (2) @(posedge clock_in);
			chk({8'h0, fa}, md[i] == 3'h3 ? 32'h123456 : 32'h3456);
		end
		wr(OFF_EA_REQ, 32'h0C00);
		repeat (2) @(posedge clock_in);
		chk({8'h0, ea}, 32'h1004);
	endtask
	task t_stack;
		wr(OFF_GEN_BASE + 8'h1C, 32'h0200);
		wr(OFF_EXC_CTRL, 32'h1);
		rc(OFF_GEN_BASE + 8'h1C, 32'h01FC);
		wr(OFF_PROGRAM_COUNTER, 32'h1111);
		wr(OFF_EXC_CTRL, 32'h2);
		rc(OFF_GEN_BASE + 8'h1C, 32'h0200);
		rc(OFF_PROGRAM_COUNTER, 32'h3456);
		wr(OFF_EXC_CTRL, 32'h4);
		rc(OFF_GEN_BASE + 8'h18, 32'h0200);
		wr(OFF_GEN_BASE + 8'h1C, 32'h0180);
		wr(OFF_EXC_CTRL, 32'h8);
		rc(OFF_GEN_BASE + 8'h1C, 32'h0200);
		wr(OFF_GEN_BASE + 8'h08, 32'hABCD);
		wr(OFF_GEN_BASE + 8'h08, 32'h1_0011);
		rc(OFF_GEN_BASE + 8'h08, 32'hAB11);
	endtask
	logic [31:0] av [9] = '{32'h8000, 32'h0, 32'h2_1234, 32'h4_0000,
		32'h10_0080, 32'h10_FF00, 32'h4_0001, 32'h8_0001, 32'h1};
	logic [3:0] an [9] = '{4'h8, 4'h4, 4'h2, 4'h5, 4'h8, 4'h4, 4'h1,
		4'h1, 4'h0};
	task t_alu;
		foreach (av[i]) begin
			wr(OFF_ALU_RESULT, av[i]);
			rc(OFF_STATUS_WORD, {28'h070, an[i]});
		end
	endtask
	initial begin
		rst_in = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		repeat (4) @(posedge clock_in);
		rst_in <= 1'b0;
		t_status();
		t_irq();
		t_pages();
		t_stack();
		t_alu();
		report_and_stop();
	end
endmodule
